// file: src/ckr_pkg.sv
package ckr_pkg;
    localparam logic [5:0] CKR_ADDR_STATUS = 6'h20;
    localparam logic [5:0] CKR_ADDR_LATCH = 6'h21;
    localparam logic [5:0] CKR_ADDR_TUNING = 6'h31;
    localparam logic [5:0] CKR_ADDR_RIDCONV = 6'h36;
    localparam logic [5:0] CKR_VEND_LO = 6'h30;
    localparam logic [5:0] CKR_VEND_HI = 6'h3F;
    localparam int CKR_ST_ID_OPEN = 0;
    localparam int CKR_ST_DATA_DET = 1;
    localparam int CKR_ST_DP_ACC = 2;
    localparam int CKR_ST_CODE_LO = 3;
    localparam int CKR_ST_CONV_DONE = 6;
    localparam int CKR_LT_ID_OPEN = 0;
    localparam int CKR_LT_DATA_DET = 1;
    localparam int CKR_LT_CONV = 3;
    localparam int CKR_LT_RSV_LO = 4;
    localparam int CKR_TN_SQUELCH_LO = 0;
    localparam int CKR_TN_BOOST_LO = 4;
    localparam logic [7:0] CKR_TUNING_WMASK = 8'h73;
    localparam logic [7:0] CKR_RESET_BYTE = 8'h00;
    localparam logic [2:0] CKR_CODE_ZERO = 3'h0;
    localparam logic [2:0] CKR_CODE_75 = 3'h1;
    localparam logic [2:0] CKR_CODE_102K = 3'h2;
    localparam logic [2:0] CKR_CODE_200K = 3'h3;
    localparam logic [2:0] CKR_CODE_FLOAT = 3'h5;
    localparam logic [2:0] CKR_CODE_ERROR = 3'h7;
    localparam int CKR_CONV_TIME_US = 282;
    localparam int CKR_CLK_MHZ = 250;
    localparam int CKR_CONV_CYCLES = CKR_CONV_TIME_US * CKR_CLK_MHZ;
endpackage

// file: src/ckr_sync.sv
`timescale 1ns/1ps
module ckr_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
    logic [W-1:0] q_next;

    // A change counts once the second and third stages agree
    always_comb begin
        q_next = q_reg;
        if (s2_reg == s3_reg) begin
            q_next = s3_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule

// file: src/ckr_regs.sv
`timescale 1ns/1ps
module ckr_regs #(
    parameter int CONV_CYCLES = ckr_pkg::CKR_CONV_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic vendor_hit,
    input wire logic id_open_pin,
    input wire logic data_detect_pin,
    input wire logic [2:0] id_resistor_pin,
    input wire logic conv_start,
    input wire logic id_open_rise_en,
    input wire logic id_open_fall_en,
    input wire logic data_detect_irq_en,
    input wire logic id_conv_irq_en_ctrl,
    input wire logic id_conv_irq_en_vend,
    output logic alt_int,
    output logic conv_busy,
    output logic [1:0] squelch_sensitivity,
    output logic [2:0] hs_drive_boost
);
    import ckr_pkg::*;

    logic id_open_flag, data_detect_compare;
    logic [2:0] res_pin_s;
    logic id_open_prev_reg, id_open_prev_next;
    logic data_det_prev_reg, data_det_prev_next;
    logic id_conv_finished_reg, id_conv_finished_next;
    logic [2:0] id_resistor_code_reg, id_resistor_code_next;
    logic [31:0] conv_cnt_reg, conv_cnt_next;
    logic busy_reg, busy_next;
    logic id_open_event_reg, id_open_event_next;
    logic data_detect_event_reg, data_detect_event_next;
    logic id_conv_event_reg, id_conv_event_next;
    logic [7:0] tuning_reg, tuning_next;
    logic [7:0] rdata_reg, rdata_next;
    logic vendor_hit_reg, vendor_hit_next;
    logic ev_id, ev_dd, ev_conv, conv_done_now, rd_latch, id_conv_irq_en;

    ckr_sync #(.W(5)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d({id_open_pin, data_detect_pin, id_resistor_pin}),
        .q({id_open_flag, data_detect_compare, res_pin_s})
    );

    assign id_conv_irq_en = id_conv_irq_en_ctrl | id_conv_irq_en_vend;
    assign conv_done_now = busy_reg && (conv_cnt_reg == 32'(CONV_CYCLES - 1));
    assign ev_id = (id_open_flag && !id_open_prev_reg && id_open_rise_en)
                || (!id_open_flag && id_open_prev_reg && id_open_fall_en);
    assign ev_dd = (data_detect_compare != data_det_prev_reg) && data_detect_irq_en;
    assign ev_conv = conv_done_now && !id_conv_finished_reg && id_conv_irq_en;
    assign rd_latch = reg_rd && (reg_addr == CKR_ADDR_LATCH);

    always_comb begin
        id_open_prev_next = id_open_flag;
        data_det_prev_next = data_detect_compare;
        busy_next = busy_reg;
        conv_cnt_next = conv_cnt_reg;
        id_resistor_code_next = id_resistor_code_reg;
        id_conv_finished_next = id_conv_finished_reg;
        if (!busy_reg && conv_start) begin
            busy_next = 1'b1;
            conv_cnt_next = '0;
        end else if (busy_reg) begin
            conv_cnt_next = conv_cnt_reg + 32'h0000_0001;
            if (conv_done_now) begin
                busy_next = 1'b0;
                id_resistor_code_next = res_pin_s;
            end
        end
        // Only the vendor conversion register read clears the flag; set wins
        if (reg_rd && reg_addr == CKR_ADDR_RIDCONV) begin
            id_conv_finished_next = 1'b0;
        end
        if (conv_done_now) begin
            id_conv_finished_next = 1'b1;
        end
        // Clear on read, a same-cycle event stays set
        id_open_event_next = (id_open_event_reg && !rd_latch) || ev_id;
        data_detect_event_next = (data_detect_event_reg && !rd_latch) || ev_dd;
        id_conv_event_next = (id_conv_event_reg && !rd_latch) || ev_conv;
        tuning_next = tuning_reg;
        if (reg_wr && reg_addr == CKR_ADDR_TUNING) begin
            tuning_next = reg_wdata & CKR_TUNING_WMASK;
        end
        // Writes to the status and latch addresses change nothing
        rdata_next = rdata_reg;
        if (reg_rd) begin
            if (reg_addr == CKR_ADDR_STATUS) begin
                rdata_next = CKR_RESET_BYTE;
                rdata_next[CKR_ST_ID_OPEN] = id_open_flag;
                rdata_next[CKR_ST_DATA_DET] = data_detect_compare;
                rdata_next[CKR_ST_DP_ACC] = 1'b0;
                rdata_next[CKR_ST_CODE_LO +: 3] = id_resistor_code_reg;
                rdata_next[CKR_ST_CONV_DONE] = id_conv_finished_reg;
            end else if (reg_addr == CKR_ADDR_LATCH) begin
                rdata_next = CKR_RESET_BYTE;
                rdata_next[CKR_LT_ID_OPEN] = id_open_event_reg;
                rdata_next[CKR_LT_DATA_DET] = data_detect_event_reg;
                rdata_next[CKR_LT_CONV] = id_conv_event_reg;
            end else if (reg_addr == CKR_ADDR_TUNING) begin
                rdata_next = tuning_reg & CKR_TUNING_WMASK;
            end else begin
                rdata_next = CKR_RESET_BYTE;
            end
        end
        vendor_hit_next = (reg_rd || reg_wr)
                       && reg_addr >= CKR_VEND_LO && reg_addr <= CKR_VEND_HI;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            id_open_prev_reg <= 1'b0;
            data_det_prev_reg <= 1'b0;
            busy_reg <= 1'b0;
            conv_cnt_reg <= '0;
            id_resistor_code_reg <= CKR_CODE_ZERO;
            id_conv_finished_reg <= 1'b0;
            id_open_event_reg <= 1'b0;
            data_detect_event_reg <= 1'b0;
            id_conv_event_reg <= 1'b0;
            tuning_reg <= CKR_RESET_BYTE;
            rdata_reg <= CKR_RESET_BYTE;
            vendor_hit_reg <= 1'b0;
        end else begin
            id_open_prev_reg <= id_open_prev_next;
            data_det_prev_reg <= data_det_prev_next;
            busy_reg <= busy_next;
            conv_cnt_reg <= conv_cnt_next;
            id_resistor_code_reg <= id_resistor_code_next;
            id_conv_finished_reg <= id_conv_finished_next;
            id_open_event_reg <= id_open_event_next;
            data_detect_event_reg <= data_detect_event_next;
            id_conv_event_reg <= id_conv_event_next;
            tuning_reg <= tuning_next;
            rdata_reg <= rdata_next;
            vendor_hit_reg <= vendor_hit_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign vendor_hit = vendor_hit_reg;
    assign alt_int = id_open_event_reg | data_detect_event_reg | id_conv_event_reg;
    assign conv_busy = busy_reg;
    assign squelch_sensitivity = tuning_reg[CKR_TN_SQUELCH_LO +: 2];
    assign hs_drive_boost = tuning_reg[CKR_TN_BOOST_LO +: 3];

    property p_latch_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_latch && !ev_id && !ev_dd && !ev_conv) |=> !alt_int;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

    property p_event_kept;
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_latch && ev_dd) |=> data_detect_event_reg;
    endproperty
    a_event_kept: assert property (p_event_kept) else $error("event lost");

    property p_status_ro;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && reg_addr == CKR_ADDR_STATUS && !reg_rd) |=> $stable(rdata_reg);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write");

    property p_done_kept;
        @(posedge clk_sys) disable iff (!rst_n)
        (id_conv_finished_reg && !(reg_rd && reg_addr == CKR_ADDR_RIDCONV))
        |=> id_conv_finished_reg;
    endproperty
    a_done_kept: assert property (p_done_kept) else $error("flag cleared");

    property p_done_set;
        @(posedge clk_sys) disable iff (!rst_n)
        conv_done_now |=> id_conv_finished_reg && !busy_reg;
    endproperty
    a_done_set: assert property (p_done_set) else $error("flag not set");

    property p_dd_event;
        @(posedge clk_sys) disable iff (!rst_n)
        ($changed(data_detect_compare) && data_detect_irq_en) |-> ##[0:1] alt_int;
    endproperty
    a_dd_event: assert property (p_dd_event) else $error("no dd event");

    property p_tuning_rsv;
        @(posedge clk_sys) disable iff (!rst_n)
        (tuning_reg & ~CKR_TUNING_WMASK) == CKR_RESET_BYTE;
    endproperty
    a_tuning_rsv: assert property (p_tuning_rsv) else $error("reserved set");

    property p_latch_rsv;
        @(posedge clk_sys) disable iff (!rst_n)
        $past(rd_latch) |-> rdata_reg[CKR_LT_RSV_LO +: 4] == 4'h0 && !rdata_reg[CKR_ST_DP_ACC];
    endproperty
    a_latch_rsv: assert property (p_latch_rsv) else $error("latch rsv");

    property p_tuning_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && reg_addr == CKR_ADDR_TUNING)
        |=> hs_drive_boost == $past(reg_wdata[CKR_TN_BOOST_LO +: 3]);
    endproperty
    a_tuning_wr: assert property (p_tuning_wr) else $error("boost wrong");
endmodule

// file: verification/ckr_link_model.sv
`timescale 1ns/1ps
module ckr_link_model (
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
    end

    // Immediate register write: one strobe cycle, released data no longer holds
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    // Immediate register read: data taken one cycle after the strobe edge
    task automatic rd(input logic [5:0] a, output logic [7:0] q);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        q = reg_rdata;
    endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ckr_pkg::*;
    typedef struct packed {logic [5:0] addr; logic [7:0] wdata; logic [7:0] exp;} ckr_row_t;
    logic clk_sys, rst_n, reg_wr, reg_rd, vendor_hit, alt_int, conv_busy, conv_start;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, q;
    logic id_open_pin, data_detect_pin, rise_en, fall_en, dd_en, cv_ctrl, cv_vend;
    logic [2:0] id_res, hs_drive_boost;
    logic [1:0] squelch_sensitivity;
    int mismatches = 0;
    int checked = 0;
    localparam int CONV_SIM = 20;
    ckr_row_t rows [5] = '{'{6'h31, 8'hFF, 8'h73}, '{6'h31, 8'h5A, 8'h52},
        '{6'h20, 8'hFF, 8'h00}, '{6'h21, 8'hFF, 8'h00}, '{6'h3F, 8'hFF, 8'h00}};

    ckr_regs #(.CONV_CYCLES(CONV_SIM)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .vendor_hit(vendor_hit), .id_open_pin(id_open_pin), .data_detect_pin(data_detect_pin),
        .id_resistor_pin(id_res), .conv_start(conv_start), .id_open_rise_en(rise_en),
        .id_open_fall_en(fall_en), .data_detect_irq_en(dd_en), .id_conv_irq_en_ctrl(cv_ctrl),
        .id_conv_irq_en_vend(cv_vend), .alt_int(alt_int), .conv_busy(conv_busy),
        .squelch_sensitivity(squelch_sensitivity), .hs_drive_boost(hs_drive_boost));
    ckr_link_model u_link (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
        u_link.rd(a, q);
        chk8(q, exp);
    endtask
    task automatic settle;
        repeat (8) @(negedge clk_sys);
    endtask
    // Starts one conversion and counts the cycles for which it stays busy
    task automatic conv_run;
        int n;
        conv_start = 1'b1;
        @(negedge clk_sys);
        conv_start = 1'b0;
        chk1(conv_busy, 1'b1);
        n = 0;
        while (conv_busy && n < 200) begin
            n++;
            @(negedge clk_sys);
        end
        chk8(8'(n), 8'(CONV_SIM));
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic results;
        $display("Counts checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        results();
    end

    initial begin
        {rst_n, conv_start, id_open_pin, data_detect_pin, rise_en, fall_en} = 6'h00;
        {dd_en, cv_ctrl, cv_vend, id_res} = 6'h00;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        rdchk(CKR_ADDR_TUNING, 8'h00);
        rdchk(CKR_ADDR_STATUS, 8'h00);
        chk1(alt_int, 1'b0);
        $display("reset test done");
        foreach (rows[i]) begin
            u_link.wr(rows[i].addr, rows[i].wdata);
            rdchk(rows[i].addr, rows[i].exp);
            chk1(vendor_hit, rows[i].addr >= CKR_VEND_LO);
            if (rows[i].addr == CKR_ADDR_TUNING)
                chk8({1'b0, hs_drive_boost, 2'b00, squelch_sensitivity}, rows[i].exp);
        end
        $display("row test done");
        dd_en = 1'b1;
        data_detect_pin = 1'b1;
        settle();
        rdchk(CKR_ADDR_STATUS, 8'h02);
        chk1(alt_int, 1'b1);
        rdchk(CKR_ADDR_LATCH, 8'h02);
        rdchk(CKR_ADDR_LATCH, 8'h00);
        chk1(alt_int, 1'b0);
        data_detect_pin = 1'b0;
        settle();
        rdchk(CKR_ADDR_LATCH, 8'h02);
        // Edge reaches the latch at the very edge that samples the next read
        data_detect_pin = 1'b1;
        repeat (3) @(negedge clk_sys);
        rdchk(CKR_ADDR_LATCH, 8'h00);
        rdchk(CKR_ADDR_LATCH, 8'h02);
        dd_en = 1'b0;
        data_detect_pin = 1'b0;
        $display("data detect test done");
        rise_en = 1'b1;
        id_open_pin = 1'b1;
        settle();
        rdchk(CKR_ADDR_STATUS, 8'h01);
        rdchk(CKR_ADDR_LATCH, 8'h01);
        rise_en = 1'b0;
        fall_en = 1'b1;
        id_open_pin = 1'b0;
        settle();
        rdchk(CKR_ADDR_LATCH, 8'h01);
        id_open_pin = 1'b1;
        settle();
        rdchk(CKR_ADDR_LATCH, 8'h00);
        id_open_pin = 1'b0;
        settle();
        u_link.rd(CKR_ADDR_LATCH, q);
        fall_en = 1'b0;
        $display("id float test done");
        id_res = CKR_CODE_FLOAT;
        cv_vend = 1'b1;
        settle();
        conv_run();
        rdchk(CKR_ADDR_STATUS, 8'h68);
        rdchk(CKR_ADDR_STATUS, 8'h68);
        rdchk(CKR_ADDR_LATCH, 8'h08);
        u_link.rd(CKR_ADDR_RIDCONV, q);
        rdchk(CKR_ADDR_STATUS, 8'h28);
        cv_vend = 1'b0;
        conv_run();
        rdchk(CKR_ADDR_LATCH, 8'h00);
        rdchk(CKR_ADDR_STATUS, 8'h68);
        u_link.rd(CKR_ADDR_RIDCONV, q);
        cv_ctrl = 1'b1;
        conv_run();
        chk1(alt_int, 1'b1);
        rdchk(CKR_ADDR_LATCH, 8'h08);
        $display("conversion test done");
        rst_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        rdchk(CKR_ADDR_TUNING, 8'h00);
        chk8({1'b0, hs_drive_boost, 2'b00, squelch_sensitivity}, 8'h00);
        rdchk(CKR_ADDR_STATUS, 8'h00);
        chk1(conv_busy, 1'b0);
        $display("mid-run reset test done");
        results();
    end
endmodule
